// ===== fsw_pkg.sv
// Constants and types shared by the fieldbus status word formatter.
package fsw_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int WORD_W  = 16;
  localparam int INT_W   = 32;
  localparam int SPEED_W = 16;
  localparam int USER_W  = 4;

  // ----------------------------------------------------------------
  // Legacy profile bit positions
  // ----------------------------------------------------------------
  localparam int LG_RDY_ON_BIT    = 0;
  localparam int LG_RDY_OP_BIT    = 1;
  localparam int LG_OP_EN_BIT     = 2;
  localparam int LG_FAULT_BIT     = 3;
  localparam int LG_COAST_BIT     = 4;
  localparam int LG_QUICK_BIT     = 5;
  localparam int LG_SW_BLOCK_BIT  = 6;
  localparam int LG_WARN_BIT      = 7;
  localparam int LG_REF_REACH_BIT = 8;
  localparam int LG_REMOTE_BIT    = 9;
  localparam int LG_ABOVE_BIT     = 10;
  localparam int LG_USER_LO_BIT   = 11;
  localparam int LG_USER_HI_BIT   = 14;
  localparam int LG_RSVD_BIT      = 15;

  // ----------------------------------------------------------------
  // Native profile bit positions
  // ----------------------------------------------------------------
  localparam int NT_READY_BIT     = 0;
  localparam int NT_RUN_EN_BIT    = 1;
  localparam int NT_RSVD_BIT      = 2;
  localparam int NT_MODULATE_BIT  = 3;
  localparam int NT_ZERO_SPD_BIT  = 4;
  localparam int NT_ACCEL_BIT     = 5;
  localparam int NT_DECEL_BIT     = 6;
  localparam int NT_AT_SETPT_BIT  = 7;
  localparam int NT_LIMIT_BIT     = 8;
  localparam int NT_SUPERV_BIT    = 9;
  localparam int NT_REV_REF_BIT   = 10;
  localparam int NT_REV_ACT_BIT   = 11;
  localparam int NT_PANEL_BIT     = 12;
  localparam int NT_FB_LOCAL_BIT  = 13;
  localparam int NT_SECOND_BIT    = 14;
  localparam int NT_FAULT_BIT     = 15;

  // ----------------------------------------------------------------
  // Reset values, masks and tolerance figures
  // ----------------------------------------------------------------
  localparam logic [WORD_W-1:0] FSW_WORD_RESET  = 16'h0000;
  localparam logic [WORD_W-1:0] FSW_NATIVE_MASK = 16'hfffb;
  localparam logic [31:0]       FSW_TOL_PCT     = 32'h0000000a;
  localparam logic [31:0]       FSW_PCT_FULL    = 32'h00000064;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic {FSW_PROF_LEGACY, FSW_PROF_NATIVE} fsw_profile_t;

  typedef enum logic [1:0] {
    FSW_LOC_LOCAL,
    FSW_LOC_FIRST_EXTERNAL_SOURCE,
    FSW_LOC_SECOND_EXTERNAL_SOURCE
  } fsw_ctrl_loc_t;

endpackage

// ===== fsw_legacy_if.sv
// Interface carrying legacy status flags to the legacy bit mapper.
`timescale 1ns/1ps
interface fsw_legacy_if;
  import fsw_pkg::*;

  logic                ready_to_switch_on;
  logic                ready_to_operate;
  logic                normal_stop_command;
  logic                operation_enabled;
  logic                fault_state_flag;
  logic                coast_stop_command;
  logic                quick_stop_command;
  logic                switch_on_blocked_flag;
  logic                warning_active;
  logic                reference_reached_flag;
  fsw_ctrl_loc_t       location;
  logic                above_limit;
  logic [USER_W-1:0]   user_bits;
  logic [WORD_W-1:0]   word;

  modport source
  (
    output ready_to_switch_on,
    output ready_to_operate,
    output normal_stop_command,
    output operation_enabled,
    output fault_state_flag,
    output coast_stop_command,
    output quick_stop_command,
    output switch_on_blocked_flag,
    output warning_active,
    output reference_reached_flag,
    output location,
    output above_limit,
    output user_bits,
    input  word
  );

  modport mapper
  (
    input  ready_to_switch_on,
    input  ready_to_operate,
    input  normal_stop_command,
    input  operation_enabled,
    input  fault_state_flag,
    input  coast_stop_command,
    input  quick_stop_command,
    input  switch_on_blocked_flag,
    input  warning_active,
    input  reference_reached_flag,
    input  location,
    input  above_limit,
    input  user_bits,
    output word
  );
endinterface

// ===== fsw_legacy_map.sv
// Combinational mapper from drive flags to the legacy status word layout.
`timescale 1ns/1ps
module fsw_legacy_map
  import fsw_pkg::*;
(
  fsw_legacy_if.mapper lg
);

  // ----------------------------------------------------------------
  // Bit layout
  // ----------------------------------------------------------------
  always_comb
  begin
    lg.word                                 = FSW_WORD_RESET;
    lg.word[LG_RDY_ON_BIT]                  = lg.ready_to_switch_on;
    lg.word[LG_RDY_OP_BIT]                  = lg.ready_to_operate &
                                              ~lg.normal_stop_command;
    lg.word[LG_OP_EN_BIT]                   = lg.operation_enabled;
    lg.word[LG_FAULT_BIT]                   = lg.fault_state_flag;
    lg.word[LG_COAST_BIT]                   = ~lg.coast_stop_command;
    lg.word[LG_QUICK_BIT]                   = ~lg.quick_stop_command;
    lg.word[LG_SW_BLOCK_BIT]                = lg.switch_on_blocked_flag;
    lg.word[LG_WARN_BIT]                    = lg.warning_active;
    lg.word[LG_REF_REACH_BIT]               = lg.reference_reached_flag;
    lg.word[LG_REMOTE_BIT]                  = (lg.location != FSW_LOC_LOCAL);
    lg.word[LG_ABOVE_BIT]                   = lg.above_limit;
    lg.word[LG_USER_HI_BIT:LG_USER_LO_BIT]  = lg.user_bits;
    lg.word[LG_RSVD_BIT]                    = 1'b0;
  end

endmodule

// ===== fsw_status_formatter.sv
// Top of the fieldbus status word formatter with its two profile layouts.
//
// Summary of operation
// - Legacy profile converts internal drive flags into its own bit layout.
// - Legacy bits 0..2: ready on, ready to operate unless normal stop, enabled.
// - Legacy bits 3..7: fault, coast and quick stop inverted, switch-on blocked, warning.
// - Legacy bit 8 set when speed error is within ten percent of nominal.
// - Legacy bit 9 set for either external control location, clear for local.
// - Legacy bit 10 set when speed magnitude reaches supervision limit, any direction.
// - Legacy bits 11..14 carry four user bits; bit 15 reserved.
// - Native profile copies internal status bits 0..15 except bit 2; upper bits unused.
// - Native bit 0 start accepted, bit 1 run enable, bit 2 reserved.
// - Native bit 3 follows output modulation.
// - Native bit 4 follows zero speed.
// - Native bits 5 and 6 follow accelerating and decelerating.
// - Native bit 7 at setpoint, bit 8 operation limited.
// - Native bit 9 set while supervised value exceeds its limit.
// - Native bits 10 and 11 give reverse reference and reverse running.
// - Native bit 12 panel local control, bit 13 fieldbus local control.
// - Native bit 14 set for second external source, clear for first.
// - Native bit 15 follows the faulted condition.
// - Only the low sixteen bits of the internal word reach the master.
`timescale 1ns/1ps
module fsw_status_formatter
  import fsw_pkg::*;
(
  // Clock and reset
  input  wire logic                          clk_sys_in,
  input  wire logic                          resetn_in,
  // Configuration
  input  wire fsw_pkg::fsw_profile_t         profile_sel_in,
  // Native internal status word
  input  wire logic [fsw_pkg::INT_W-1:0]     internal_status_in,
  // Legacy state and supervision flags
  input  wire logic                          ready_to_switch_on_in,
  input  wire logic                          ready_to_operate_in,
  input  wire logic                          normal_stop_command_in,
  input  wire logic                          operation_enabled_in,
  input  wire logic                          fault_state_flag_in,
  input  wire logic                          coast_stop_command_in,
  input  wire logic                          quick_stop_command_in,
  input  wire logic                          switch_on_blocked_flag_in,
  input  wire logic                          warning_active_in,
  input  wire fsw_pkg::fsw_ctrl_loc_t        control_location_in,
  input  wire logic [fsw_pkg::USER_W-1:0]    user_status_in,
  // Speed supervision values
  input  wire logic signed [fsw_pkg::SPEED_W-1:0] actual_speed_in,
  input  wire logic signed [fsw_pkg::SPEED_W-1:0] reference_speed_in,
  input  wire logic [fsw_pkg::SPEED_W-1:0]   nominal_speed_in,
  input  wire logic [fsw_pkg::SPEED_W-1:0]   supervision_limit_in,
  // Status words toward the fieldbus master
  output logic [fsw_pkg::WORD_W-1:0]         status_word_out,
  output logic [fsw_pkg::WORD_W-1:0]         legacy_status_word_out,
  output logic [fsw_pkg::WORD_W-1:0]         native_status_word_out,
  output fsw_pkg::fsw_profile_t              active_profile_out,
  output logic                               status_change_out
);
  import fsw_pkg::*;

  // ----------------------------------------------------------------
  // Speed supervision
  // ----------------------------------------------------------------
  logic signed [SPEED_W:0] speed_err;
  logic [SPEED_W:0]        err_mag;
  logic [SPEED_W:0]        act_mag;
  logic                    reference_reached_flag;
  logic                    above_limit;

  assign speed_err = SPEED_W'(0) + (SPEED_W+1)'(actual_speed_in) -
                     (SPEED_W+1)'(reference_speed_in);

  always_comb
  begin
    err_mag = speed_err[SPEED_W] ? (SPEED_W+1)'(-speed_err) : speed_err;
    act_mag = actual_speed_in[SPEED_W-1] ?
              (SPEED_W+1)'(-(SPEED_W+1)'(actual_speed_in)) :
              (SPEED_W+1)'(actual_speed_in);
  end

  // The error is scaled by the full percentage so no division is needed.
  assign reference_reached_flag = (32'(err_mag) * FSW_PCT_FULL) <=
                                  (32'(nominal_speed_in) * FSW_TOL_PCT);
  // The magnitude covers both rotation directions.
  assign above_limit = act_mag >= (SPEED_W+1)'(supervision_limit_in);

  // ----------------------------------------------------------------
  // Legacy layout
  // ----------------------------------------------------------------
  fsw_legacy_if lg_if ();

  assign lg_if.ready_to_switch_on     = ready_to_switch_on_in;
  assign lg_if.ready_to_operate       = ready_to_operate_in;
  assign lg_if.normal_stop_command    = normal_stop_command_in;
  assign lg_if.operation_enabled      = operation_enabled_in;
  assign lg_if.fault_state_flag       = fault_state_flag_in;
  assign lg_if.coast_stop_command     = coast_stop_command_in;
  assign lg_if.quick_stop_command     = quick_stop_command_in;
  assign lg_if.switch_on_blocked_flag = switch_on_blocked_flag_in;
  assign lg_if.warning_active         = warning_active_in;
  assign lg_if.reference_reached_flag = reference_reached_flag;
  assign lg_if.location               = control_location_in;
  assign lg_if.above_limit            = above_limit;
  assign lg_if.user_bits              = user_status_in;

  fsw_legacy_map u_legacy_map
  (
    .lg (lg_if.mapper)
  );

  // ----------------------------------------------------------------
  // Native layout
  // ----------------------------------------------------------------
  logic [WORD_W-1:0] native_word;

  // Bits 16 and up of the internal word are dropped; bit 2 reads zero.
  assign native_word = internal_status_in[WORD_W-1:0] &
                       FSW_NATIVE_MASK;

  // ----------------------------------------------------------------
  // Profile selection and output registers
  // ----------------------------------------------------------------
  logic [WORD_W-1:0] status_word_d;
  logic [WORD_W-1:0] status_word_q;
  logic [WORD_W-1:0] legacy_word_q;
  logic [WORD_W-1:0] native_word_q;
  fsw_profile_t      profile_q;
  logic              change_q;

  always_comb
  begin
    case (profile_sel_in)
      FSW_PROF_LEGACY: status_word_d = lg_if.word;
      FSW_PROF_NATIVE: status_word_d = native_word;
      default:         status_word_d = FSW_WORD_RESET;
    endcase
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (!resetn_in)
    begin
      status_word_q <= FSW_WORD_RESET;
    end
    else
    begin
      status_word_q <= status_word_d;
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (!resetn_in)
    begin
      legacy_word_q <= FSW_WORD_RESET;
      native_word_q <= FSW_WORD_RESET;
    end
    else
    begin
      legacy_word_q <= lg_if.word;
      native_word_q <= native_word;
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (!resetn_in)
    begin
      profile_q <= FSW_PROF_LEGACY;
    end
    else
    begin
      profile_q <= profile_sel_in;
    end
  end

  // One-cycle pulse whenever the word presented to the master changes.
  always_ff @(posedge clk_sys_in)
  begin
    if (!resetn_in)
    begin
      change_q <= 1'b0;
    end
    else
    begin
      change_q <= (status_word_d != status_word_q);
    end
  end

  assign status_word_out        = status_word_q;
  assign legacy_status_word_out = legacy_word_q;
  assign native_status_word_out = native_word_q;
  assign active_profile_out     = profile_q;
  assign status_change_out      = change_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic legacy_sel;
  logic native_sel;

  assign legacy_sel = (profile_sel_in == FSW_PROF_LEGACY);
  assign native_sel = (profile_sel_in == FSW_PROF_NATIVE);

  // The checks start one edge after reset release. At the releasing edge the
  // disable condition already sees reset high while the words still hold zero.
  logic check_armed_q;

  always_ff @(posedge clk_sys_in)
  begin
    if (!resetn_in)
    begin
      check_armed_q <= 1'b0;
    end
    else
    begin
      check_armed_q <= 1'b1;
    end
  end

  a_legacy_ready_bits: assert property (
    @(posedge clk_sys_in) disable iff (!resetn_in || !check_armed_q)
    legacy_sel |=> (status_word_out[LG_RDY_ON_BIT] == $past(ready_to_switch_on_in)) &&
                   (status_word_out[LG_RDY_OP_BIT] ==
                    ($past(ready_to_operate_in) && !$past(normal_stop_command_in))) &&
                   (status_word_out[LG_OP_EN_BIT] == $past(operation_enabled_in)))
    else $error("Legacy ready bits do not follow the drive state.");

  a_legacy_stop_bits: assert property (
    @(posedge clk_sys_in) disable iff (!resetn_in || !check_armed_q)
    (legacy_sel && coast_stop_command_in && !quick_stop_command_in) |=>
      !status_word_out[LG_COAST_BIT] && status_word_out[LG_QUICK_BIT])
    else $error("Legacy stop bits are not active low.");

  a_legacy_fault_warn: assert property (
    @(posedge clk_sys_in) disable iff (!resetn_in || !check_armed_q)
    legacy_sel |=> (status_word_out[LG_FAULT_BIT] == $past(fault_state_flag_in)) &&
                   (status_word_out[LG_SW_BLOCK_BIT] == $past(switch_on_blocked_flag_in)) &&
                   (status_word_out[LG_WARN_BIT] == $past(warning_active_in)))
    else $error("Legacy fault, blocked or warning bit is wrong.");

  a_legacy_ref_reach: assert property (
    @(posedge clk_sys_in) disable iff (!resetn_in || !check_armed_q)
    (legacy_sel && (actual_speed_in == reference_speed_in)) |=>
      status_word_out[LG_REF_REACH_BIT])
    else $error("Zero speed error did not report reference reached.");

  a_legacy_remote: assert property (
    @(posedge clk_sys_in) disable iff (!resetn_in || !check_armed_q)
    legacy_sel |=> status_word_out[LG_REMOTE_BIT] ==
                   ($past(control_location_in) != FSW_LOC_LOCAL))
    else $error("Remote bit does not follow the control location.");

  a_legacy_above: assert property (
    @(posedge clk_sys_in) disable iff (!resetn_in || !check_armed_q)
    (legacy_sel && (supervision_limit_in == 16'h0000)) |=>
      status_word_out[LG_ABOVE_BIT])
    else $error("Above-limit bit clear with a zero limit.");

  a_legacy_below: assert property (
    @(posedge clk_sys_in) disable iff (!resetn_in || !check_armed_q)
    (legacy_sel && (actual_speed_in == 16'sh0000) && (supervision_limit_in != 16'h0000)) |=>
      !status_word_out[LG_ABOVE_BIT])
    else $error("Above-limit bit set at standstill with a nonzero limit.");

  a_legacy_user_rsvd: assert property (
    @(posedge clk_sys_in) disable iff (!resetn_in || !check_armed_q)
    legacy_sel |=> (status_word_out[LG_USER_HI_BIT:LG_USER_LO_BIT] ==
                    $past(user_status_in)) && !status_word_out[LG_RSVD_BIT])
    else $error("User bits or reserved bit wrong in legacy word.");

  a_native_copy: assert property (
    @(posedge clk_sys_in) disable iff (!resetn_in || !check_armed_q)
    native_sel |=> status_word_out == $past(native_word))
    else $error("Native word is not a copy of the internal status.");

  a_native_rsvd_zero: assert property (
    @(posedge clk_sys_in) disable iff (!resetn_in || !check_armed_q)
    native_sel ##1 native_sel |-> !status_word_out[NT_RSVD_BIT])
    else $error("Reserved native bit reads one.");

  a_native_fault_dir: assert property (
    @(posedge clk_sys_in) disable iff (!resetn_in || !check_armed_q)
    (native_sel && internal_status_in[NT_FAULT_BIT] &&
     internal_status_in[NT_SECOND_BIT]) |=>
      status_word_out[NT_FAULT_BIT] && status_word_out[NT_SECOND_BIT])
    else $error("Native fault or second source bit lost.");

  a_native_motion: assert property (
    @(posedge clk_sys_in) disable iff (!resetn_in || !check_armed_q)
    native_sel |=> (status_word_out[NT_ACCEL_BIT] == $past(internal_status_in[NT_ACCEL_BIT]))
                && (status_word_out[NT_DECEL_BIT] == $past(internal_status_in[NT_DECEL_BIT])))
    else $error("Native motion bits not copied.");

  a_upper_ignored: assert property (
    @(posedge clk_sys_in) disable iff (!resetn_in || !check_armed_q)
    (native_sel && $stable(internal_status_in[WORD_W-1:0]) && $past(native_sel) &&
     $past(resetn_in)) |=> $stable(status_word_out))
    else $error("Upper internal bits disturbed the status word.");

  a_change_pulse: assert property (
    @(posedge clk_sys_in) disable iff (!resetn_in || !check_armed_q)
    $changed(status_word_out) |-> status_change_out)
    else $error("Word change without a change pulse.");

  a_change_quiet: assert property (
    @(posedge clk_sys_in) disable iff (!resetn_in || !check_armed_q)
    !$changed(status_word_out) |-> !status_change_out)
    else $error("Change pulse without a word change.");

  a_profile_track: assert property (
    @(posedge clk_sys_in) disable iff (!resetn_in || !check_armed_q)
    (native_sel ##1 legacy_sel) |=> active_profile_out == FSW_PROF_LEGACY &&
                                    status_word_out == legacy_status_word_out)
    else $error("Profile switch not reflected at the output.");

endmodule

// ===== fsw_master_model.sv
// Fieldbus master model that polls the formatted status word.
`timescale 1ns/1ps
module fsw_master_model
(
  // Clock and reset
  input  wire logic                      clk_sys_in,
  input  wire logic                      resetn_in,
  // Status word offered by the drive
  input  wire logic [fsw_pkg::WORD_W-1:0] status_word_in,
  // Poll results
  output logic [fsw_pkg::WORD_W-1:0]      polled_word_out,
  output logic [31:0]                     poll_count_out
);
  import fsw_pkg::*;

  // The master polls mid-cycle, when the registered word has settled.
  // Only the sixteen-bit converted word is visible to it.
  always @(negedge clk_sys_in)
  begin
    if (!resetn_in)
    begin
      polled_word_out <= 16'h0000;
      poll_count_out  <= 32'h00000000;
    end
    else
    begin
      polled_word_out <= status_word_in;
      poll_count_out  <= poll_count_out + 32'h00000001;
    end
  end
endmodule

// ===== fsw_tb.sv
// Self-checking testbench for the fieldbus status word formatter.
`timescale 1ns/1ps
module tb;
  import fsw_pkg::*;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic                      clk_sys_in;
  logic                      resetn_in;
  fsw_profile_t              profile_sel;
  logic [INT_W-1:0]          internal_status;
  logic [8:0]                flags;
  fsw_ctrl_loc_t             loc;
  logic [USER_W-1:0]         user;
  logic signed [SPEED_W-1:0] act;
  logic signed [SPEED_W-1:0] ref_spd;
  logic [SPEED_W-1:0]        nom;
  logic [SPEED_W-1:0]        lim;
  logic [WORD_W-1:0]         sw;
  logic [WORD_W-1:0]         lw;
  logic [WORD_W-1:0]         nw;
  fsw_profile_t              ap;
  logic                      chg;
  logic [WORD_W-1:0]         polled;
  logic [WORD_W-1:0]         prev_word;
  logic [31:0]               seed;
  int                        fail_count;
  int                        n_checks;
  int                        cycles;

  fsw_status_formatter DUT (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
    .profile_sel_in(profile_sel), .internal_status_in(internal_status),
    .ready_to_switch_on_in(flags[0]), .ready_to_operate_in(flags[1]),
    .normal_stop_command_in(flags[2]), .operation_enabled_in(flags[3]),
    .fault_state_flag_in(flags[4]), .coast_stop_command_in(flags[5]),
    .quick_stop_command_in(flags[6]), .switch_on_blocked_flag_in(flags[7]),
    .warning_active_in(flags[8]), .control_location_in(loc), .user_status_in(user),
    .actual_speed_in(act), .reference_speed_in(ref_spd), .nominal_speed_in(nom),
    .supervision_limit_in(lim), .status_word_out(sw), .legacy_status_word_out(lw),
    .native_status_word_out(nw), .active_profile_out(ap), .status_change_out(chg));

  fsw_master_model master (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
    .status_word_in(sw), .polled_word_out(polled), .poll_count_out());

  // ----------------------------------------------------------------
  // Expectations and helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] exp_legacy();
    int          err;
    int          mag;
    logic [15:0] w;
    err = int'(act) - int'(ref_spd);
    if (err < 0) err = -err;
    mag = (int'(act) < 0) ? -int'(act) : int'(act);
    w = {1'b0, user, (mag >= int'(lim)), (loc != FSW_LOC_LOCAL),
         (err * 100 <= int'(nom) * 10), flags[8:7], ~flags[6], ~flags[5],
         flags[4], flags[3], flags[1] & ~flags[2], flags[0]};
    return w;
  endfunction

  function automatic logic [15:0] exp_native();
    return {internal_status[15:3], 1'b0, internal_status[1:0]};
  endfunction

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] expd);
    n_checks++;
    if (seen !== expd)
    begin
      fail_count++;
      $display("wrong value at %0t ns: seen %h expected %h", $time, seen, expd);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Waits for the edge that samples the new inputs, then compares mid-cycle.
  task automatic step();
    logic [15:0] e;
    @(posedge clk_sys_in);
    @(negedge clk_sys_in);
    #1;
    e = (profile_sel == FSW_PROF_NATIVE) ? exp_native() : exp_legacy();
    check(lw, exp_legacy());
    check(nw, exp_native());
    check(sw, e);
    check(polled, e);
    check({15'h0000, ap}, {15'h0000, profile_sel});
    check({15'h0000, chg}, {15'h0000, e != prev_word});
    prev_word = e;
  endtask

  task automatic check_reset();
    @(negedge clk_sys_in);
    #1;
    check(sw, 16'h0000);
    check(lw, 16'h0000);
    check(nw, 16'h0000);
    check({14'h0000, ap, chg}, 16'h0000);
    check(polled, 16'h0000);
    prev_word = 16'h0000;
  endtask

  task automatic speeds(input logic [15:0] a, input logic [15:0] r,
                        input logic [15:0] n, input logic [15:0] l);
    @(posedge clk_sys_in);
    act     <= a;
    ref_spd <= r;
    nom     <= n;
    lim     <= l;
    step();
  endtask

  task automatic drive_random();
    logic [31:0] a;
    logic [31:0] b;
    a = xs();
    b = xs();
    @(posedge clk_sys_in);
    profile_sel     <= fsw_profile_t'(a[0]);
    internal_status <= xs();
    flags           <= a[9:1];
    loc             <= fsw_ctrl_loc_t'((a[11:10] == 2'd3) ? 2'd1 : a[11:10]);
    user            <= a[15:12];
    act             <= b[15:0];
    ref_spd         <= b[15:0] ^ {9'h000, a[22:16]};
    nom             <= b[31:16];
    lim             <= a[31:16];
    step();
  endtask

  // ----------------------------------------------------------------
  // Clock, timeout and main sequence
  // ----------------------------------------------------------------
  initial
  begin
    clk_sys_in = 1'b0;
    forever #50 clk_sys_in = ~clk_sys_in;
  end

  always @(posedge clk_sys_in)
  begin
    cycles++;
    if (cycles >= 3000)
    begin
      fail_count++;
      report_and_stop();
    end
  end

  initial
  begin
    seed = 32'h44f7aa00;
    fail_count = 0;
    n_checks = 0;
    cycles = 0;
    resetn_in = 1'b0;
    profile_sel = FSW_PROF_NATIVE;
    internal_status = 32'hffffffff;
    flags = 9'h1ff;
    loc = FSW_LOC_SECOND_EXTERNAL_SOURCE;
    user = 4'hf;
    act = 16'sh7fff;
    ref_spd = 16'sh0000;
    nom = 16'h0064;
    lim = 16'h00c8;
    repeat (20) @(posedge clk_sys_in);
    check_reset();
    @(posedge clk_sys_in);
    resetn_in <= 1'b1;
    step();
    $display("test reset and native all-ones done");
    for (int i = 0; i < 16; i++)
    begin
      @(posedge clk_sys_in);
      internal_status <= (32'h00000001 << i) | 32'hffff0000;
      step();
    end
    @(posedge clk_sys_in);
    internal_status <= {16'h5ac3, internal_status[15:0]};
    step();
    $display("test native walking bit done");
    for (int i = 0; i < 10; i++)
    begin
      @(posedge clk_sys_in);
      profile_sel <= FSW_PROF_LEGACY;
      flags <= (i == 9) ? 9'h003 : (9'h001 << i);
      step();
    end
    for (int i = 0; i < 3; i++)
    begin
      @(posedge clk_sys_in);
      loc <= fsw_ctrl_loc_t'(i[1:0]);
      step();
    end
    $display("test legacy flags and locations done");
    speeds(16'h006e, 16'h0064, 16'h0064, 16'h00c8);
    speeds(16'h006f, 16'h0064, 16'h0064, 16'h006f);
    speeds(16'hff38, 16'hff42, 16'h0064, 16'h00c8);
    speeds(16'hff39, 16'h0000, 16'h0000, 16'h00c8);
    speeds(16'h0000, 16'h0000, 16'h0000, 16'h0000);
    speeds(16'h0000, 16'h0005, 16'h0064, 16'h0001);
    $display("test speed tolerance and limit done");
    repeat (150) drive_random();
    $display("test random done");
    @(posedge clk_sys_in);
    resetn_in <= 1'b0;
    @(posedge clk_sys_in);
    check_reset();
    @(posedge clk_sys_in);
    resetn_in <= 1'b1;
    step();
    repeat (20) drive_random();
    $display("test reset in mid-run done");
    report_and_stop();
  end
endmodule
